// >>> rtl/ueh_endpoint_ctrl.v
// Endpoint handshake control: registers, flags, interrupt and token answers
`timescale 1ns/100ps
`default_nettype none
`include "ueh_regs.vh"
module ueh_endpoint_ctrl #(
  parameter CNT_W = 4
) (
  input wire clock,
  input wire rst,
  input wire [`UEH_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata_r,
  input wire tok_valid,
  input wire [1:0] tok_kind,
  input wire [1:0] tok_ep,
  input wire tx_acked,
  input wire rx_acked,
  output reg hs_valid_r,
  output reg [1:0] hs_code_r,
  output reg data_pid1_r,
  output reg [CNT_W-1:0] tx_count_r,
  output reg setup_seen_r,
  output reg irq_r
);
  reg ep0_tx_ie_r;
  reg ep0_rx_ie_r;
  reg ep12_tx_ie_r;
  reg ep0_toggle_r;
  reg ep0_stall_r;
  reg ep0_tx_en_r;
  reg ep0_rx_en_r;
  reg [CNT_W-1:0] ep0_count_r;
  reg ep12_toggle_r;
  reg ep_select_r;
  reg ep12_tx_en_r;
  reg ep1_en_r;
  reg ep2_en_r;
  reg ep1_stall_r;
  reg ep2_stall_r;
  // Which endpoint the last token was addressed to: 0 = ep0, 1 = any other endpoint (ep1, ep2 or ep3)
  reg pend_ep12_r;
  reg pend_in_r;
  reg pend_out_r;
  wire ep0_tx_flag;
  wire ep0_rx_flag;
  wire ep12_tx_flag;
  wire [1:0] answer;
  wire wr_ep0_int;
  wire wr_ep12_int;
  wire wr_ep0_ctrl;
  wire wr_ep12_ctrl;
  wire wr_ep12_en;
  wire clr_ep0_tx;
  wire clr_ep0_rx;
  wire clr_ep12_tx;
  wire set_ep0_tx;
  wire set_ep0_rx;
  wire set_ep12_tx;
  wire setup_tok;
  wire irq_nxt;
  reg [7:0] rdata_nxt;
  wire ep0_tx_ok;
  wire ep0_rx_ok;
  wire ep12_tx_ok;
  wire tok_is_ep0;
  wire tok_is_in;
  wire hs_valid_nxt;
  wire [1:0] hs_code_nxt;
  wire data_pid1_nxt;
  wire [CNT_W-1:0] tx_count_nxt;
  wire setup_seen_nxt;
  wire pend_in_nxt;
  wire pend_out_nxt;
  wire irq_ep0_tx;
  wire irq_ep0_rx;
  wire irq_ep12_tx;

  assign wr_ep0_int = reg_write && (reg_addr == `UEH_OFS_EP0_INT);
  assign wr_ep12_int = reg_write && (reg_addr == `UEH_OFS_EP12_INT);
  assign wr_ep0_ctrl = reg_write && (reg_addr == `UEH_OFS_EP0_CTRL);
  assign wr_ep12_ctrl = reg_write && (reg_addr == `UEH_OFS_EP12_CTRL);
  assign wr_ep12_en = reg_write && (reg_addr == `UEH_OFS_EP12_EN);

  // Clear strobes act only on a one; the strobe bits are never stored
  assign clr_ep0_tx = wr_ep0_int && reg_wdata[`UEH_B_EP0_TX_CLR];
  assign clr_ep0_rx = wr_ep0_int && reg_wdata[`UEH_B_EP0_RX_CLR];
  assign clr_ep12_tx = wr_ep12_int && reg_wdata[`UEH_B_EP12_TX_CLR];

  // Completion comes from the link after the ACK of the answered token
  assign set_ep0_tx = tx_acked && pend_in_r && !pend_ep12_r;
  assign set_ep12_tx = tx_acked && pend_in_r && pend_ep12_r;
  assign set_ep0_rx = rx_acked && pend_out_r;
  assign setup_tok = tok_valid && (tok_kind == `UEH_TOK_SETUP) && (tok_ep == 2'h0);

  // Endpoint 0 transmit completion
  ueh_sticky_flag u_ep0_tx_flag (
    .clock(clock),
    .rst(rst),
    .set_pulse(set_ep0_tx),
    .clear_pulse(clr_ep0_tx),
    .flag_r(ep0_tx_flag)
  );

  // Endpoint 0 receive completion
  ueh_sticky_flag u_ep0_rx_flag (
    .clock(clock),
    .rst(rst),
    .set_pulse(set_ep0_rx),
    .clear_pulse(clr_ep0_rx),
    .flag_r(ep0_rx_flag)
  );

  // Shared endpoint 1/2 transmit completion
  ueh_sticky_flag u_ep12_tx_flag (
    .clock(clock),
    .rst(rst),
    .set_pulse(set_ep12_tx),
    .clear_pulse(clr_ep12_tx),
    .flag_r(ep12_tx_flag)
  );

  ueh_token_decide u_decide (
    .tok_kind(tok_kind),
    .tok_ep(tok_ep),
    .ep0_stall(ep0_stall_r),
    .ep0_tx_ok(ep0_tx_ok),
    .ep0_rx_ok(ep0_rx_ok),
    .ep12_tx_ok(ep12_tx_ok),
    .ep_select(ep_select_r),
    .ep1_enable(ep1_en_r),
    .ep2_enable(ep2_en_r),
    .ep1_stall(ep1_stall_r),
    .ep2_stall(ep2_stall_r),
    .answer(answer)
  );

  // Interrupt enables of endpoint 0; the clear strobes beside them are never stored
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ep0_tx_ie_r <= 1'b0;
      ep0_rx_ie_r <= 1'b0;
    end else if (wr_ep0_int) begin
      ep0_tx_ie_r <= reg_wdata[`UEH_B_EP0_TX_IE];
      ep0_rx_ie_r <= reg_wdata[`UEH_B_EP0_RX_IE];
    end
  end

  // Interrupt enable of the shared endpoint 1/2 flag
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ep12_tx_ie_r <= 1'b0;
    end else if (wr_ep12_int) begin
      ep12_tx_ie_r <= reg_wdata[`UEH_B_EP12_TX_IE];
    end
  end

  // Endpoint 0 control; toggle and count change only by software
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ep0_toggle_r <= 1'b0;
      ep0_tx_en_r <= 1'b0;
      ep0_rx_en_r <= 1'b0;
      ep0_count_r <= {CNT_W{1'b0}};
    end else if (wr_ep0_ctrl) begin
      ep0_toggle_r <= reg_wdata[`UEH_B_EP0_TOGGLE];
      ep0_tx_en_r <= reg_wdata[`UEH_B_EP0_TX_EN];
      ep0_rx_en_r <= reg_wdata[`UEH_B_EP0_RX_EN];
      ep0_count_r <= reg_wdata[`UEH_F_CNT_HI:`UEH_F_CNT_LO];
    end
  end

  // A SETUP in the write cycle wins, so a stale stall cannot survive it
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ep0_stall_r <= 1'b0;
    end else if (setup_tok) begin
      ep0_stall_r <= 1'b0;
    end else if (wr_ep0_ctrl) begin
      ep0_stall_r <= reg_wdata[`UEH_B_EP0_STALL];
    end
  end

  // Shared buffer control: toggle, endpoint select and transmit enable
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ep12_toggle_r <= 1'b0;
      ep_select_r <= 1'b0;
      ep12_tx_en_r <= 1'b0;
    end else if (wr_ep12_ctrl) begin
      ep12_toggle_r <= reg_wdata[`UEH_B_EP12_TOGGLE];
      ep_select_r <= reg_wdata[`UEH_B_EP_SELECT];
      ep12_tx_en_r <= reg_wdata[`UEH_B_EP12_TX_EN];
    end
  end

  // Endpoint 1/2 enables and stalls; a disabled endpoint stays silent
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ep2_en_r <= 1'b0;
      ep1_en_r <= 1'b0;
      ep2_stall_r <= 1'b0;
      ep1_stall_r <= 1'b0;
    end else if (wr_ep12_en) begin
      ep2_en_r <= reg_wdata[`UEH_B_EP2_EN];
      ep1_en_r <= reg_wdata[`UEH_B_EP1_EN];
      ep2_stall_r <= reg_wdata[`UEH_B_EP2_STALL];
      ep1_stall_r <= reg_wdata[`UEH_B_EP1_STALL];
    end
  end

  // Readiness of each buffer: enabled by software and its flag not pending
  assign ep0_tx_ok = ep0_tx_en_r && !ep0_tx_flag;
  assign ep0_rx_ok = ep0_rx_en_r && !ep0_rx_flag;
  assign ep12_tx_ok = ep12_tx_en_r && !ep12_tx_flag;
  assign tok_is_ep0 = (tok_ep == 2'h0);
  assign tok_is_in = (tok_kind == `UEH_TOK_IN);

  // Answer of this cycle's token; code, PID and count hold until the next token
  assign hs_valid_nxt = tok_valid && (answer != `UEH_HS_NONE);
  assign hs_code_nxt = tok_valid ? answer : hs_code_r;
  assign setup_seen_nxt = tok_valid ? setup_tok : setup_seen_r;
  // Toggles are never changed here; software flips them
  assign data_pid1_nxt = !tok_valid ? data_pid1_r :
                         (tok_is_ep0 ? ep0_toggle_r : ep12_toggle_r);
  // Endpoint 1/2 packet size lives outside this block; only ep0 count is held
  assign tx_count_nxt = !tok_valid ? tx_count_r :
                        (tok_is_ep0 ? ep0_count_r : {CNT_W{1'b0}});
  // A pending transfer waits for its acknowledge; a new token replaces it
  assign pend_in_nxt = tok_valid ? (tok_is_in && (answer == `UEH_HS_ACK)) :
                       (pend_in_r && !tx_acked);
  assign pend_out_nxt = tok_valid ? (!tok_is_in && (answer == `UEH_HS_ACK) && tok_is_ep0) :
                        (pend_out_r && !rx_acked);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_valid_r <= 1'b0;
      hs_code_r <= `UEH_HS_NONE;
      data_pid1_r <= 1'b0;
      tx_count_r <= {CNT_W{1'b0}};
      setup_seen_r <= 1'b0;
      pend_in_r <= 1'b0;
      pend_out_r <= 1'b0;
      pend_ep12_r <= 1'b0;
    end else begin
      hs_valid_r <= hs_valid_nxt;
      hs_code_r <= hs_code_nxt;
      data_pid1_r <= data_pid1_nxt;
      tx_count_r <= tx_count_nxt;
      setup_seen_r <= setup_seen_nxt;
      pend_in_r <= pend_in_nxt;
      pend_out_r <= pend_out_nxt;
      if (tok_valid) begin
        pend_ep12_r <= !tok_is_ep0;
      end
    end
  end

  // Level request, held until software clears the flags or their interrupt enables
  assign irq_ep0_tx = ep0_tx_flag && ep0_tx_ie_r;
  assign irq_ep0_rx = ep0_rx_flag && ep0_rx_ie_r;
  assign irq_ep12_tx = ep12_tx_flag && ep12_tx_ie_r;
  assign irq_nxt = irq_ep0_tx || irq_ep0_rx || irq_ep12_tx;

  always @* begin
    rdata_nxt = `UEH_BYTE_ZERO;
    if (reg_addr == `UEH_OFS_EP0_INT) begin
      rdata_nxt[`UEH_B_EP0_TX_FLAG] = ep0_tx_flag;
      rdata_nxt[`UEH_B_EP0_RX_FLAG] = ep0_rx_flag;
      rdata_nxt[`UEH_B_EP0_TX_IE] = ep0_tx_ie_r;
      rdata_nxt[`UEH_B_EP0_RX_IE] = ep0_rx_ie_r;
    end else if (reg_addr == `UEH_OFS_EP12_INT) begin
      rdata_nxt[`UEH_B_EP12_TX_FLAG] = ep12_tx_flag;
      rdata_nxt[`UEH_B_EP12_TX_IE] = ep12_tx_ie_r;
    end else if (reg_addr == `UEH_OFS_EP0_CTRL) begin
      rdata_nxt[`UEH_B_EP0_TOGGLE] = ep0_toggle_r;
      rdata_nxt[`UEH_B_EP0_STALL] = ep0_stall_r;
      rdata_nxt[`UEH_B_EP0_TX_EN] = ep0_tx_en_r;
      rdata_nxt[`UEH_B_EP0_RX_EN] = ep0_rx_en_r;
      rdata_nxt[`UEH_F_CNT_HI:`UEH_F_CNT_LO] = ep0_count_r;
    end else if (reg_addr == `UEH_OFS_EP12_CTRL) begin
      rdata_nxt[`UEH_B_EP12_TOGGLE] = ep12_toggle_r;
      rdata_nxt[`UEH_B_EP_SELECT] = ep_select_r;
      rdata_nxt[`UEH_B_EP12_TX_EN] = ep12_tx_en_r;
    end else if (reg_addr == `UEH_OFS_EP12_EN) begin
      rdata_nxt[`UEH_B_EP2_EN] = ep2_en_r;
      rdata_nxt[`UEH_B_EP1_EN] = ep1_en_r;
      rdata_nxt[`UEH_B_EP2_STALL] = ep2_stall_r;
      rdata_nxt[`UEH_B_EP1_STALL] = ep1_stall_r;
    end
  end

  // Registered request; it lags the flag by one cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Read data only in the cycle after the strobe; zero otherwise
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= `UEH_BYTE_ZERO;
    end else begin
      reg_rdata_r <= reg_read ? rdata_nxt : `UEH_BYTE_ZERO;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ueh_regs.vh
// Register offsets, field positions and codes of the endpoint handshake control block
`ifndef UEH_REGS_VH
`define UEH_REGS_VH

`define UEH_ADDR_W 3
`define UEH_OFS_EP0_INT 3'h0
`define UEH_OFS_EP12_INT 3'h1
`define UEH_OFS_EP0_CTRL 3'h2
`define UEH_OFS_EP12_CTRL 3'h3
`define UEH_OFS_EP12_EN 3'h4

// Endpoint 0 interrupt register
`define UEH_B_EP0_TX_FLAG 7
`define UEH_B_EP0_RX_FLAG 6
`define UEH_B_EP0_TX_IE 5
`define UEH_B_EP0_RX_IE 4
`define UEH_B_EP0_TX_CLR 3
`define UEH_B_EP0_RX_CLR 2
// Endpoint 1/2 interrupt register
`define UEH_B_EP12_TX_FLAG 7
`define UEH_B_EP12_TX_IE 5
`define UEH_B_EP12_TX_CLR 3
// Endpoint 0 control register
`define UEH_B_EP0_TOGGLE 7
`define UEH_B_EP0_STALL 6
`define UEH_B_EP0_TX_EN 5
`define UEH_B_EP0_RX_EN 4
`define UEH_F_CNT_HI 3
`define UEH_F_CNT_LO 0
// Endpoint 1/2 control register
`define UEH_B_EP12_TOGGLE 7
`define UEH_B_EP_SELECT 6
`define UEH_B_EP12_TX_EN 5
// Endpoint 1/2 enable register
`define UEH_B_EP2_EN 3
`define UEH_B_EP1_EN 2
`define UEH_B_EP2_STALL 1
`define UEH_B_EP1_STALL 0

// Token kinds
`define UEH_TOK_IN 2'h0
`define UEH_TOK_OUT 2'h1
`define UEH_TOK_SETUP 2'h2
// Handshake answers
`define UEH_HS_NONE 2'h0
`define UEH_HS_ACK 2'h1
`define UEH_HS_NAK 2'h2
`define UEH_HS_STALL 2'h3

`define UEH_BYTE_ZERO 8'h00
`endif

// >>> rtl/ueh_sticky_flag.v
// Sticky completion flag: hardware set, software clear, set wins
`timescale 1ns/100ps
`default_nettype none
module ueh_sticky_flag (
  input wire clock,
  input wire rst,
  input wire set_pulse,
  input wire clear_pulse,
  output reg flag_r
);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (set_pulse) begin
      // A completion in the clear cycle must not be lost
      flag_r <= 1'b1;
    end else if (clear_pulse) begin
      flag_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ueh_token_decide.v
// Combinational handshake decision for one token
`timescale 1ns/100ps
`default_nettype none
`include "ueh_regs.vh"
module ueh_token_decide (
  input wire [1:0] tok_kind,
  input wire [1:0] tok_ep,
  input wire ep0_stall,
  input wire ep0_tx_ok,
  input wire ep0_rx_ok,
  input wire ep12_tx_ok,
  input wire ep_select,
  input wire ep1_enable,
  input wire ep2_enable,
  input wire ep1_stall,
  input wire ep2_stall,
  output reg [1:0] answer
);
  always @* begin
    answer = `UEH_HS_NONE;
    if (tok_ep == 2'h0) begin
      if (tok_kind == `UEH_TOK_SETUP) begin
        answer = `UEH_HS_ACK;
      end else if (ep0_stall) begin
        answer = `UEH_HS_STALL;
      end else if (tok_kind == `UEH_TOK_IN) begin
        answer = ep0_tx_ok ? `UEH_HS_ACK : `UEH_HS_NAK;
      end else if (tok_kind == `UEH_TOK_OUT) begin
        answer = ep0_rx_ok ? `UEH_HS_ACK : `UEH_HS_NAK;
      end
    end else if (tok_ep == 2'h1) begin
      if (!ep1_enable) begin
        answer = `UEH_HS_NONE;
      end else if (ep1_stall) begin
        answer = `UEH_HS_STALL;
      end else if (tok_kind == `UEH_TOK_IN) begin
        answer = (ep12_tx_ok && !ep_select) ? `UEH_HS_ACK : `UEH_HS_NAK;
      end
    end else if (tok_ep == 2'h2) begin
      if (!ep2_enable) begin
        answer = `UEH_HS_NONE;
      end else if (ep2_stall) begin
        answer = `UEH_HS_STALL;
      end else if (tok_kind == `UEH_TOK_IN) begin
        answer = (ep12_tx_ok && ep_select) ? `UEH_HS_ACK : `UEH_HS_NAK;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/ueh_endpoint_ctrl_sva.sv
// Port checker of the endpoint handshake control block
`timescale 1ns/100ps
`default_nettype none
`include "ueh_regs.vh"
module ueh_endpoint_ctrl_sva #(
  parameter CNT_W = 4
) (
  input wire clock,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata_r,
  input wire tok_valid,
  input wire [1:0] tok_kind,
  input wire [1:0] tok_ep,
  input wire tx_acked,
  input wire rx_acked,
  input wire hs_valid_r,
  input wire [1:0] hs_code_r,
  input wire data_pid1_r,
  input wire [CNT_W-1:0] tx_count_r,
  input wire setup_seen_r,
  input wire irq_r
);
  // Shadows of the software-written bits, so answers can be tied to settings
  reg [7:0] c0_r, c12_r, en_r;
  reg [2:0] ie_r;
  wire ep0_tok = tok_valid && tok_ep == 2'h0;
  wire setup0 = ep0_tok && tok_kind == `UEH_TOK_SETUP;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      c0_r <= 8'h00;
      c12_r <= 8'h00;
      en_r <= 8'h00;
      ie_r <= 3'h0;
    end else begin
      if (reg_write && reg_addr == `UEH_OFS_EP0_CTRL)
        c0_r <= reg_wdata;
      // A SETUP in the write cycle beats the written stall bit
      if (setup0)
        c0_r[6] <= 1'b0;
      if (reg_write && reg_addr == `UEH_OFS_EP12_CTRL)
        c12_r <= reg_wdata;
      if (reg_write && reg_addr == `UEH_OFS_EP12_EN)
        en_r <= reg_wdata;
      if (reg_write && reg_addr == `UEH_OFS_EP0_INT)
        ie_r[1:0] <= reg_wdata[5:4];
      if (reg_write && reg_addr == `UEH_OFS_EP12_INT)
        ie_r[2] <= reg_wdata[5];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ep0_answered: assert property (ep0_tok |=> hs_valid_r)
    else $error("ep0 token without answer");
  a_strobe_reads0: assert property ($past(reg_read) && $past(reg_addr) == 3'h0 |-> reg_rdata_r[3:2] == 2'h0)
    else $error("clear strobe bits read nonzero");
  a_setup_acked: assert property (setup0 |=> hs_code_r == `UEH_HS_ACK && setup_seen_r)
    else $error("setup not acknowledged");
  a_ep0_stalls: assert property (ep0_tok && !setup0 && c0_r[6] |=> hs_code_r == `UEH_HS_STALL)
    else $error("stall bit ignored");
  a_in_nak: assert property (ep0_tok && tok_kind == `UEH_TOK_IN && !c0_r[6] && !c0_r[5]
    |=> hs_code_r == `UEH_HS_NAK)
    else $error("ep0 in not refused");
  a_out_nak: assert property (ep0_tok && tok_kind == `UEH_TOK_OUT && !c0_r[6] && !c0_r[4]
    |=> hs_code_r == `UEH_HS_NAK)
    else $error("ep0 out not refused");
  a_ep2_select: assert property (tok_valid && tok_kind == `UEH_TOK_IN && tok_ep == 2'h2 &&
    !c12_r[6] && en_r[3] && !en_r[1] |=> hs_code_r == `UEH_HS_NAK)
    else $error("ep2 answered while buffer on ep1");
  a_ep1_disabled: assert property (tok_valid && tok_ep == 2'h1 && !en_r[2]
    |=> hs_code_r == `UEH_HS_NONE)
    else $error("disabled ep1 answered");
  a_irq_needs_ie: assert property (irq_r |-> $past(|ie_r))
    else $error("irq without enable");
  a_irq_rx: assert property (rx_acked && ie_r[0] |-> ##2 irq_r)
    else $error("rx irq missing");
endmodule
bind ueh_endpoint_ctrl ueh_endpoint_ctrl_sva #(.CNT_W(CNT_W)) u_sva (.clock, .rst, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata_r, .tok_valid, .tok_kind, .tok_ep, .tx_acked,
  .rx_acked, .hs_valid_r, .hs_code_r, .data_pid1_r, .tx_count_r, .setup_seen_r, .irq_r);
`default_nettype wire

// >>> testbench/ueh_host_model.sv
// Host controller model: issues tokens and acknowledges data packets
`timescale 1ns/100ps
`default_nettype none
`include "ueh_regs.vh"
module ueh_host_model (
  input wire clock,
  input wire [1:0] hs_code_r,
  output logic tok_valid,
  output logic [1:0] tok_kind,
  output logic [1:0] tok_ep,
  output logic tx_acked,
  output logic rx_acked
);
  initial begin
    tok_valid = 1'b0;
    tok_kind = 2'h3;
    tok_ep = 2'h3;
    tx_acked = 1'b0;
    rx_acked = 1'b0;
  end
  task send(input logic [1:0] kind, input logic [1:0] ep);
    begin
      @(posedge clock);
      tok_valid <= 1'b1;
      tok_kind <= kind;
      tok_ep <= ep;
      @(posedge clock);
      tok_valid <= 1'b0;
      // Released lines show the inverse so stale values are never mistaken for a token
      tok_kind <= ~kind;
      tok_ep <= ~ep;
      @(negedge clock);
      if (hs_code_r == `UEH_HS_ACK && kind == `UEH_TOK_IN) begin
        @(posedge clock);
        tx_acked <= 1'b1;
        @(posedge clock);
        tx_acked <= 1'b0;
      end else if (hs_code_r == `UEH_HS_ACK && ep == 2'h0) begin
        @(posedge clock);
        rx_acked <= 1'b1;
        @(posedge clock);
        rx_acked <= 1'b0;
      end
      @(negedge clock);
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/ueh_endpoint_ctrl_tb.sv
// Self-checking bench of the endpoint handshake control block
`timescale 1ns/100ps
`default_nettype none
`include "ueh_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module ueh_endpoint_ctrl_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata_r;
  wire tok_valid, tx_acked, rx_acked, hs_valid_r, data_pid1_r, setup_seen_r, irq_r;
  wire [1:0] tok_kind, tok_ep, hs_code_r;
  wire [3:0] tx_count_r;
  int n_fail = 0;
  int n_tests = 0;
  always #50 clock = ~clock;
  ueh_endpoint_ctrl #(.CNT_W(4)) uut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata_r, .tok_valid, .tok_kind, .tok_ep, .tx_acked, .rx_acked,
    .hs_valid_r, .hs_code_r, .data_pid1_r, .tx_count_r, .setup_seen_r, .irq_r);
  ueh_host_model host (.clock, .hs_code_r, .tok_valid, .tok_kind, .tok_ep, .tx_acked,
    .rx_acked);
  task wr(input logic [2:0] a, input logic [7:0] d);
    begin
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
    end
  endtask
  task rdc(input logic [2:0] a, input logic [7:0] exp);
    begin
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      `CHK(reg_rdata_r, exp)
    end
  endtask
  task tk(input logic [1:0] kind, input logic [1:0] ep, input logic [1:0] exp);
    begin
      host.send(kind, ep);
      `CHK(hs_code_r, exp)
    end
  endtask
  task results;
    begin
      if (n_fail == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task t_reset;
    for (int i = 0; i < 6; i++) rdc(i[2:0], 8'h00);
  endtask
  task t_ep0_in;
    begin
      wr(3'h0, 8'h20);
      wr(3'h2, 8'hA5);
      tk(`UEH_TOK_IN, 2'h0, `UEH_HS_ACK);
      `CHK(data_pid1_r, 1'b1)
      `CHK(tx_count_r, 4'h5)
      rdc(3'h0, 8'hA0);
      `CHK(irq_r, 1'b1)
      tk(`UEH_TOK_IN, 2'h0, `UEH_HS_NAK);
      rdc(3'h2, 8'hA5);
      wr(3'h0, 8'h20);
      rdc(3'h0, 8'hA0);
      wr(3'h0, 8'h08);
      rdc(3'h0, 8'h00);
      `CHK(irq_r, 1'b0)
      wr(3'h2, 8'h23);
      tk(`UEH_TOK_IN, 2'h0, `UEH_HS_ACK);
      `CHK(data_pid1_r, 1'b0)
      rdc(3'h0, 8'h80);
      `CHK(irq_r, 1'b0)
      wr(3'h0, 8'h08);
      wr(3'h2, 8'h00);
    end
  endtask
  task t_ep0_out;
    begin
      wr(3'h0, 8'h10);
      tk(`UEH_TOK_OUT, 2'h0, `UEH_HS_NAK);
      wr(3'h2, 8'h10);
      tk(`UEH_TOK_OUT, 2'h0, `UEH_HS_ACK);
      rdc(3'h0, 8'h50);
      `CHK(irq_r, 1'b1)
      tk(`UEH_TOK_OUT, 2'h0, `UEH_HS_NAK);
      wr(3'h0, 8'h04);
      rdc(3'h0, 8'h00);
    end
  endtask
  task t_stall;
    begin
      wr(3'h2, 8'h70);
      tk(`UEH_TOK_IN, 2'h0, `UEH_HS_STALL);
      tk(`UEH_TOK_OUT, 2'h0, `UEH_HS_STALL);
      tk(`UEH_TOK_SETUP, 2'h0, `UEH_HS_ACK);
      `CHK(setup_seen_r, 1'b1)
      rdc(3'h2, 8'h30);
      wr(3'h0, 8'h04);
      wr(3'h2, 8'h00);
    end
  endtask
  task t_ep12;
    begin
      wr(3'h4, 8'h08);
      wr(3'h3, 8'h20);
      tk(`UEH_TOK_IN, 2'h2, `UEH_HS_NAK);
      tk(`UEH_TOK_IN, 2'h1, `UEH_HS_NONE);
      wr(3'h3, 8'hE0);
      wr(3'h1, 8'h20);
      tk(`UEH_TOK_IN, 2'h2, `UEH_HS_ACK);
      `CHK(data_pid1_r, 1'b1)
      rdc(3'h1, 8'hA0);
      `CHK(irq_r, 1'b1)
      tk(`UEH_TOK_IN, 2'h2, `UEH_HS_NAK);
      wr(3'h1, 8'hA0);
      rdc(3'h1, 8'hA0);
      wr(3'h1, 8'h08);
      rdc(3'h1, 8'h00);
      wr(3'h3, 8'h40);
      tk(`UEH_TOK_IN, 2'h2, `UEH_HS_NAK);
    end
  endtask
  // Fixed-length drivers only; the watchdog bounds the whole run
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    results;
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_ep0_in;
    t_ep0_out;
    t_stall;
    t_ep12;
    results;
  end
endmodule
`default_nettype wire
